//--- bench/fspd_fan_model.sv
/*
 * fspd_fan_model: square-wave tach output of a fan for the bench.
 * assumes halfCyc is changed only while run is low.
 */
`timescale 1ns/10ps
`default_nettype none
module fspd_fan_model (
    // clock
    input wire logic sys_clk,
    // control from the bench
    input wire logic run,
    input wire logic [7:0] halfCyc,
    // tach pin
    output logic fanOut
);
    logic [7:0] cnt = 8'h00;
    logic lvl = 1'b0;
    // a stopped fan parks its output low, so stopping never adds a rise
    always @(posedge sys_clk) begin
        if (!run) begin
            cnt <= 8'h00;
            lvl <= 1'b0;
        end else if (cnt == halfCyc - 8'h01) begin
            cnt <= 8'h00;
            lvl <= ~lvl;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    assign fanOut = lvl;
endmodule
`default_nettype wire

//--- bench/fspd_monitor_tb.sv
/*
 * fspd_monitor_tb: self-checking bench of the fan speed monitor.
 * assumes the fan model on the pin and a shortened reference divider.
 */
`timescale 1ns/10ps
`default_nettype none
module fspd_monitor_tb
    import fspd_pkg::*;
;
    // four clocks per reference tick keeps intervals short; saturation stays out of reach
    localparam int DIV = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    fspd_req_t regReq = '0;
    logic [DATA_W-1:0] regRdata;
    logic tachIrq;
    logic fanPulseIn;
    logic fanRun = 1'b0;
    logic [7:0] halfCyc = 8'h10;
    logic [15:0] lfsr = 16'h4446;
    logic [DATA_W-1:0] rv;
    int errCount = 0;
    int checksDone = 0;
    int edgeTab [4] = '{2, 3, 5, 9};
    int h;
    int k;
    int e;

    fspd_monitor #(.REF_DIV_P(DIV)) dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .regReq(regReq),
        .regRdata(regRdata),
        .fanPulseIn(fanPulseIn),
        .tachIrq(tachIrq)
    );
    fspd_fan_model fan (
        .sys_clk(sys_clk),
        .run(fanRun),
        .halfCyc(halfCyc),
        .fanOut(fanPulseIn)
    );

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsrStep(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // an interval of n edges spans n-1 half periods
    function automatic int expTicks(input int sel, input int hc);
        return (edgeTab[sel] - 1) * hc / DIV;
    endfunction

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic checkEq(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // tick phase against the fan edges allows one count either way
    task automatic checkNear(input string what, input int exp, input logic [15:0] got);
        checksDone++;
        if ($isunknown(got) || int'(got) > exp + 1 || int'(got) < exp - 1) begin
            errCount++;
            $display("CHECK FAILED %s expected %0d seen %h", what, exp, got);
        end
    endtask

    task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regReq.addr <= a;
        regReq.wdata <= d;
        regReq.wr <= 1'b1;
        @(posedge sys_clk);
        regReq.wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        @(posedge sys_clk);
        regReq.rd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic waitReady();
        for (int i = 0; i < 1000; i++) begin
            rdReg(OFS_STAT, rv);
            if (rv[ST_RDY_BIT] === 1'b1) begin
                return;
            end
        end
        errCount++;
        $display("CHECK FAILED count ready expected 1 seen 0");
        stopTest();
    endtask

    // n rises, then the pin parks low
    task automatic burst(input int hc, input int n);
        halfCyc <= 8'(hc);
        fanRun <= 1'b1;
        repeat ((2 * n - 1) * hc + hc / 2) @(posedge sys_clk);
        fanRun <= 1'b0;
        repeat (30) @(posedge sys_clk);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdReg(OFS_CTRL, rv);
        checkEq("ctrl reset", 32'h0000_0000, rv);
        rdReg(OFS_STAT, rv);
        checkEq("status reset", 32'h0000_0000, rv);
        rdReg(OFS_HI, rv);
        checkEq("high reset", 32'h0000_FFFF, rv);
        rdReg(OFS_LO, rv);
        checkEq("low reset", 32'h0000_0000, rv);
        wrReg(4'h2, 32'hFFFF_FFFF);
        rdReg(4'h2, rv);
        checkEq("unmapped", 32'h0000_0000, rv);
        wrReg(OFS_CTRL, 32'hFFFF_FFFF);
        rdReg(OFS_CTRL, rv);
        checkEq("ctrl rw", 32'h0000_DD01, rv);
        wrReg(OFS_CTRL, 32'h0000_0000);
        // mode 0: free count of rises
        wrReg(OFS_CTRL, 32'h0000_0001);
        lfsr = lfsrStep(lfsr);
        k = 1 + int'(lfsr[3:0]);
        burst(10, k);
        rdReg(OFS_CTRL, rv);
        checkEq("free count", 32'(k), 32'(rv[31:16]));
        rdReg(OFS_CTRL, rv);
        burst(10, 5);
        rdReg(OFS_CTRL, rv);
        checkEq("free count after read", 32'(k + 5), 32'(rv[31:16]));
        checkEq("toggle irq masked", 32'h0000_0000, {31'h0, tachIrq});
        // the toggle interrupt stays off while togIe is clear; switching straight from free to gated mode
        wrReg(OFS_CTRL, 32'h0000_8401);
        repeat (2) @(posedge sys_clk);
        #1;
        checkEq("toggle irq on", 32'h0000_0001, {31'h0, tachIrq});
        wrReg(OFS_STAT, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        #1;
        checkEq("irq cleared", 32'h0000_0000, {31'h0, tachIrq});
        wrReg(OFS_CTRL, 32'h0000_0000);
        burst(10, 4);
        rdReg(OFS_CTRL, rv);
        checkEq("disabled count", 32'(k + 5), 32'(rv[31:16]));
        // filter drops pulses shorter than two ticks, keeps wide ones
        wrReg(OFS_CTRL, 32'h0000_0101);
        burst(2, 10);
        // one and a half reference periods must not pass either
        burst(6, 4);
        rdReg(OFS_CTRL, rv);
        checkEq("glitches dropped", 32'(k + 5), 32'(rv[31:16]));
        burst(40, 3);
        rdReg(OFS_CTRL, rv);
        checkEq("filtered count", 32'h0000_0003, 32'(rv[31:16]));
        wrReg(OFS_CTRL, 32'h0000_0000);
        // mode 1 over every edge selection, ready enable on odd ones
        for (int s = 0; s < 4; s++) begin
            lfsr = lfsrStep(lfsr);
            h = 8 * (2 + int'(lfsr[2:0]));
            e = expTicks(s, h);
            halfCyc <= 8'(h);
            fanRun <= 1'b1;
            wrReg(OFS_CTRL, 32'h0000_0401 | (32'(s) << 11) | (32'(s & 1) << 14));
            waitReady();
            wrReg(OFS_STAT, 32'h0000_0007);
            waitReady();
            rdReg(OFS_CTRL, rv);
            checkNear("gated count", e, rv[31:16]);
            checkEq("ready irq", 32'(s & 1), {31'h0, tachIrq});
            wrReg(OFS_STAT, 32'h0000_0007);
            waitReady();
            rdReg(OFS_CTRL, rv);
            checkNear("next count", e, rv[31:16]);
            fanRun <= 1'b0;
            wrReg(OFS_CTRL, 32'h0000_0000);
        end
        // limits: half period 40 over two edges reads 10 ticks
        halfCyc <= 8'h28;
        fanRun <= 1'b1;
        wrReg(OFS_CTRL, 32'h0000_0401);
        for (int i = 0; i < 3; i++) begin
            wrReg(OFS_HI, i == 0 ? 32'h0000_0005 : 32'h0000_FFFF);
            wrReg(OFS_LO, i == 1 ? 32'h0000_0014 : 32'h0000_0000);
            wrReg(OFS_STAT, 32'h0000_0007);
            waitReady();
            rdReg(OFS_STAT, rv);
            checkEq("range flag", 32'(i < 2), 32'(rv[ST_OOL_BIT]));
            checkEq("range irq", 32'(i < 2), {31'h0, tachIrq});
        end
        fanRun <= 1'b0;
        stopTest();
    end
endmodule
`default_nettype wire

//--- rtl/fspd_filter.sv
/*
 * fspd_filter: synchroniser and glitch filter for the fan pulse pin.
 * assumes refTick is a one-cycle enable at the reference rate and rstN is
 * already synchronised to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module fspd_filter
    import fspd_pkg::*;
#(
    parameter int TICKS = FILT_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstN,
    // control
    input wire logic refTick,
    input wire logic filtEn,
    // pin and clean level
    input wire logic fanPulseIn,
    output logic level
);

    // the tick counter is two bits wide
    if (TICKS < 1 || TICKS > 3) begin
        $error("fspd_filter: TICKS out of range");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [1:0] stable;
    } fspd_flt_st_t;

    fspd_flt_st_t q, n;

    always_comb begin
        n = q;
        n.sync1 = fanPulseIn;
        n.sync2 = q.sync1;
        if (!filtEn) begin
            n.level = q.sync2;
            n.stable = 2'h0;
        end else if (q.sync2 == q.level) begin
            n.stable = 2'h0;
        end else if (refTick) begin
            // seen on TICKS+1 ticks in a row, so the pulse outlasted TICKS periods
            if (q.stable == 2'(TICKS)) begin
                n.level = q.sync2;
                n.stable = 2'h0;
            end else begin
                n.stable = q.stable + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level = q.level;

    default clocking cbF @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    property p_filter_tick;
        $past(filtEn) && filtEn && $changed(q.level) |-> $past(refTick);
    endproperty
    a_filter_tick: assert property (p_filter_tick)
        else $error("filtered level moved without a reference tick");

endmodule
`default_nettype wire

//--- rtl/fspd_monitor.sv
/*
 * fspd_monitor: fan speed monitor with free-running and reference-gated
 * measurement, limit check and one interrupt output.
 * assumes a single 200 MHz clock, a register port with one-cycle strobes
 * and read data one cycle later, and an asynchronous fan pulse pin.
 */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module fspd_monitor
    import fspd_pkg::*;
#(
    parameter int REF_DIV_P = REF_DIV
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire fspd_req_t regReq,
    output logic [DATA_W-1:0] regRdata,
    // fan side
    input wire logic fanPulseIn,
    // interrupt
    output logic tachIrq
);

    localparam int DIV_W = $clog2(REF_DIV_P);

    // divider needs at least two phases and fits twelve bits
    if (REF_DIV_P < 2 || REF_DIV_P > 4096) begin
        $error("fspd_monitor: REF_DIV_P out of range");
    end

    typedef struct packed {
        logic [DIV_W-1:0] divCnt;
        fspd_ctrl_t ctl;
        logic [CNT_W-1:0] hiLim;
        logic [CNT_W-1:0] loLim;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] countField;
        logic [3:0] edgeCnt;
        logic prevLevel;
        logic ool;
        logic tog;
        logic rdy;
        fspd_state_t state;
        logic [DATA_W-1:0] rdata;
    } fspd_st_t;

    fspd_st_t q, n;
    logic rstMetaN;
    logic rstN;
    logic level;
    logic refTick;
    logic rise;
    logic anyEdge;
    logic edgeHit;
    logic satHit;
    logic latch;
    logic [CNT_W-1:0] latchVal;
    logic [3:0] edgeTarget;
    logic setOol;
    logic [DATA_W-1:0] clrMask;
    logic [DATA_W-1:0] ctlWord;
    logic [DATA_W-1:0] statWord;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMetaN <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMetaN <= 1'b1;
            rstN <= rstMetaN;
        end
    end

    fspd_filter #(
        .TICKS(FILT_TICKS)
    ) u_filter (
        .sys_clk(sys_clk),
        .rstN(rstN),
        .refTick(refTick),
        .filtEn(q.ctl.filtEn),
        .fanPulseIn(fanPulseIn),
        .level(level)
    );

    always_comb begin
        n = q;
        latch = 1'b0;
        latchVal = q.countField;
        edgeHit = 1'b0;
        satHit = 1'b0;
        setOol = 1'b0;
        clrMask = '0;

        // reference rate as a one-cycle enable
        refTick = (q.divCnt == DIV_W'(REF_DIV_P - 1));
        n.divCnt = refTick ? '0 : q.divCnt + DIV_W'(1);

        rise = level && !q.prevLevel;
        anyEdge = level ^ q.prevLevel;
        n.prevLevel = level;
        edgeTarget = fspd_edges(q.ctl.edgeSel);

        case (q.state)
            ST_IDLE: begin
                n.cnt = CNT_ZERO;
                n.edgeCnt = '0;
                if (q.ctl.en) begin
                    n.state = q.ctl.mode ? ST_GATED : ST_FREE;
                end
            end
            ST_FREE: begin
                if (!q.ctl.en || q.ctl.mode) begin
                    n.state = ST_IDLE;
                end else if (rise) begin
                    // wraps naturally at the field width
                    n.cnt = q.cnt + CNT_ONE;
                    latch = 1'b1;
                    latchVal = q.cnt + CNT_ONE;
                end
            end
            ST_GATED: begin
                edgeHit = anyEdge && (q.edgeCnt != '0) && (q.edgeCnt + 4'h1 == edgeTarget);
                satHit = refTick && (q.cnt == CNT_NEAR_MAX);
                if (!q.ctl.en || !q.ctl.mode) begin
                    n.state = ST_IDLE;
                end else if (edgeHit) begin
                    // the closing edge also opens the next interval
                    latch = 1'b1;
                    latchVal = q.cnt;
                    n.rdy = 1'b1;
                    n.cnt = CNT_ZERO;
                    n.edgeCnt = EDGE_FIRST;
                end else if (satHit) begin
                    // stalled fan: a full count means the selected number of edges did not arrive within ~655 ms
                    latch = 1'b1;
                    latchVal = CNT_MAX;
                    n.rdy = 1'b1;
                    n.cnt = CNT_ZERO;
                    n.edgeCnt = '0;
                end else if (anyEdge && q.edgeCnt == '0) begin
                    // first edge restarts timing so the first interval is honest
                    n.cnt = CNT_ZERO;
                    n.edgeCnt = EDGE_FIRST;
                end else begin
                    if (anyEdge) begin
                        n.edgeCnt = q.edgeCnt + 4'h1;
                    end
                    if (refTick) begin
                        n.cnt = q.cnt + CNT_ONE;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        if (latch) begin
            n.countField = latchVal;
            setOol = (latchVal > q.hiLim) || (latchVal < q.loLim);
        end

        // register writes
        if (regReq.wr) begin
            case (regReq.addr)
                OFS_CTRL: begin
                    n.ctl.en = regReq.wdata[CTL_EN_BIT];
                    n.ctl.filtEn = regReq.wdata[CTL_FILT_BIT];
                    n.ctl.mode = regReq.wdata[CTL_MODE_BIT];
                    n.ctl.edgeSel = regReq.wdata[CTL_EDGE_LSB +: 2];
                    n.ctl.rdyIe = regReq.wdata[CTL_RDYIE_BIT];
                    n.ctl.togIe = regReq.wdata[CTL_TOGIE_BIT];
                end
                OFS_STAT: clrMask = regReq.wdata;
                OFS_HI: n.hiLim = regReq.wdata[CNT_W-1:0];
                OFS_LO: n.loLim = regReq.wdata[CNT_W-1:0];
                default: clrMask = '0;
            endcase
        end

        // set beats a same-cycle clear
        n.ool = (q.ool && !clrMask[ST_OOL_BIT]) || setOol;
        n.tog = (q.tog && !clrMask[ST_TOG_BIT]) || (anyEdge && q.ctl.en);
        n.rdy = (q.rdy && !clrMask[ST_RDY_BIT]) || (n.rdy && !q.rdy) || (latch && q.state == ST_GATED);

        // read data stands only in the cycle after the strobe; reads change nothing
        ctlWord = '0;
        ctlWord[CTL_CNT_LSB +: CNT_W] = q.countField;
        ctlWord[CTL_TOGIE_BIT] = q.ctl.togIe;
        ctlWord[CTL_RDYIE_BIT] = q.ctl.rdyIe;
        ctlWord[CTL_EDGE_LSB +: 2] = q.ctl.edgeSel;
        ctlWord[CTL_MODE_BIT] = q.ctl.mode;
        ctlWord[CTL_FILT_BIT] = q.ctl.filtEn;
        ctlWord[CTL_EN_BIT] = q.ctl.en;
        statWord = '0;
        statWord[ST_OOL_BIT] = q.ool;
        statWord[ST_TOG_BIT] = q.tog;
        statWord[ST_RDY_BIT] = q.rdy;
        n.rdata = '0;
        if (regReq.rd) begin
            case (regReq.addr)
                OFS_CTRL: n.rdata = ctlWord;
                OFS_STAT: n.rdata = statWord;
                OFS_HI: n.rdata = {{(DATA_W - CNT_W){1'b0}}, q.hiLim};
                OFS_LO: n.rdata = {{(DATA_W - CNT_W){1'b0}}, q.loLim};
                default: n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
            q.hiLim <= HI_RST;
            q.loLim <= LO_RST;
            q.state <= ST_IDLE;
        end else begin
            q <= n;
        end
    end

    assign regRdata = q.rdata;
    // enables gate only the event kinds that have one; out of limit always fires
    assign tachIrq = q.ool || (q.rdy && q.ctl.rdyIe) || (q.tog && q.ctl.togIe);

    default clocking cbM @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    sequence s_gatedEdgeDone;
        q.state == ST_GATED && q.ctl.en && q.ctl.mode && edgeHit;
    endsequence

    sequence s_saturate;
        q.state == ST_GATED && q.ctl.en && q.ctl.mode && !edgeHit && satHit;
    endsequence

    sequence s_freeRise;
        q.state == ST_FREE && q.ctl.en && !q.ctl.mode && rise;
    endsequence

    property p_free_inc;
        s_freeRise |=> (q.cnt == $past(q.cnt) + CNT_ONE) && (q.countField == q.cnt);
    endproperty
    a_free_inc: assert property (p_free_inc)
        else $error("free count did not follow a rising edge");

    property p_free_wrap;
        s_freeRise ##0 (q.cnt == CNT_MAX) |=> q.cnt == CNT_ZERO ##0 q.countField == CNT_ZERO;
    endproperty
    a_free_wrap: assert property (p_free_wrap)
        else $error("free count did not wrap to zero");

    property p_read_quiet;
        q.state == ST_FREE && q.ctl.en && !q.ctl.mode && !rise && regReq.rd |=> $stable(q.cnt);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("a read altered the counter");

    property p_edge_latch;
        s_gatedEdgeDone |=> q.rdy && (q.countField == $past(q.cnt));
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("count not latched at programmed edge");

    property p_edge_clear;
        s_gatedEdgeDone |=> q.cnt == CNT_ZERO && q.edgeCnt == EDGE_FIRST;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("counter not cleared after copy");

    property p_saturate;
        s_saturate |=> q.countField == CNT_MAX && q.cnt == CNT_ZERO && q.rdy;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("saturated count not latched");

    property p_limit;
        latch && (latchVal > q.hiLim || latchVal < q.loLim) |=> q.ool;
    endproperty
    a_limit: assert property (p_limit)
        else $error("out of range count did not set the flag");

    property p_ool_irq;
        q.ool |-> tachIrq;
    endproperty
    a_ool_irq: assert property (p_ool_irq)
        else $error("out of limit flag without interrupt");

    property p_rdy_irq;
        q.rdy && q.ctl.rdyIe |-> tachIrq;
    endproperty
    a_rdy_irq: assert property (p_rdy_irq)
        else $error("enabled count ready without interrupt");

    property p_irq_cause;
        tachIrq |-> q.ool || q.rdy || q.tog;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt with no status event");

    property p_mode_switch;
        (q.state == ST_FREE && q.ctl.en && q.ctl.mode) ##1 (q.ctl.en && q.ctl.mode) |-> ##1 q.state == ST_GATED;
    endproperty
    a_mode_switch: assert property (p_mode_switch)
        else $error("mode select did not reach gated counting");

    property p_tog_irq;
        q.tog && q.ctl.togIe |-> tachIrq;
    endproperty
    a_tog_irq: assert property (p_tog_irq)
        else $error("enabled toggle event without interrupt");

    property p_idle_hold;
        q.state == ST_IDLE && !q.ctl.en |=> $stable(q.countField) && q.cnt == CNT_ZERO;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("stopped monitor changed its count");

endmodule
`default_nettype wire

//--- rtl/fspd_pkg.sv
/*
 * fspd_pkg: shared constants, field positions and carrier types of the
 * fan speed monitor.
 * assumes a 200 MHz system clock and a 32-bit byte-addressed register port.
 */
package fspd_pkg;

    // clocking
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int REF_CLK_HZ = 100_000;
    localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
    localparam int FILT_TICKS = 2;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_HI = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_LO = 4'hC;

    // control field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_FILT_BIT = 8;
    localparam int CTL_MODE_BIT = 10;
    localparam int CTL_EDGE_LSB = 11;
    localparam int CTL_RDYIE_BIT = 14;
    localparam int CTL_TOGIE_BIT = 15;
    localparam int CTL_CNT_LSB = 16;

    // status field positions, write one to clear
    localparam int ST_OOL_BIT = 0;
    localparam int ST_TOG_BIT = 1;
    localparam int ST_RDY_BIT = 2;

    // reset values and counter limits
    localparam logic [CNT_W-1:0] HI_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] LO_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_NEAR_MAX = 16'hFFFE;

    // measurement interval lengths in input edges
    localparam logic [3:0] EDGES_SEL0 = 4'h2;
    localparam logic [3:0] EDGES_SEL1 = 4'h3;
    localparam logic [3:0] EDGES_SEL2 = 4'h5;
    localparam logic [3:0] EDGES_SEL3 = 4'h9;
    localparam logic [3:0] EDGE_FIRST = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FREE = 3'b010,
        ST_GATED = 3'b100
    } fspd_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } fspd_req_t;

    typedef struct packed {
        logic togIe;
        logic rdyIe;
        logic [1:0] edgeSel;
        logic mode;
        logic filtEn;
        logic en;
    } fspd_ctrl_t;

    function automatic logic [3:0] fspd_edges(input logic [1:0] sel);
        case (sel)
            2'h0: return EDGES_SEL0;
            2'h1: return EDGES_SEL1;
            2'h2: return EDGES_SEL2;
            default: return EDGES_SEL3;
        endcase
    endfunction

endpackage
